/* File: rtl/fpres_defines.svh */
`ifndef FPRES_DEFINES_SVH
`define FPRES_DEFINES_SVH

// default destination layout: single format
`define FPRES_EXP_W         8
`define FPRES_FRAC_W        23
// bits of the exact result below the last kept place
`define FPRES_EXT_W         4

// rounding control codes
`define FPRES_RND_NEAREST   2'h0
`define FPRES_RND_DOWN      2'h1
`define FPRES_RND_UP        2'h2
`define FPRES_RND_TRUNC     2'h3

// unit mode codes
`define FPRES_MODE_STACK    1'h0
`define FPRES_MODE_PACKED   1'h1

// sign bit of the indefinite value
`define FPRES_INDEF_SIGN    1'h1

`endif

/* File: rtl/fpres_pkg.sv */
`include "fpres_defines.svh"

package fpres_pkg;

	// rounding mode as carried by rounding_control_field
	typedef enum logic [1:0] {
		FPRES_RND_NEAR  = `FPRES_RND_NEAREST,
		FPRES_RND_DOWN  = `FPRES_RND_DOWN,
		FPRES_RND_UP    = `FPRES_RND_UP,
		FPRES_RND_TRUNC = `FPRES_RND_TRUNC
	} fpres_rnd_t;

	// execution unit that issued the operation
	typedef enum logic {
		FPRES_MODE_STACK  = `FPRES_MODE_STACK,
		FPRES_MODE_PACKED = `FPRES_MODE_PACKED
	} fpres_mode_t;

endpackage : fpres_pkg

/* File: rtl/fpres_round.sv */
`timescale 1ns/10ps
`include "fpres_defines.svh"

module fpres_round #(
	parameter int EXP_W  = `FPRES_EXP_W,
	parameter int FRAC_W = `FPRES_FRAC_W,
	parameter int EXT_W  = `FPRES_EXT_W
) (
	input  wire logic                    sign,
	input  wire logic [EXP_W+FRAC_W-1:0] mag,
	input  wire logic [EXT_W-1:0]        ext,
	input  wire fpres_pkg::fpres_rnd_t   rnd_mode,
	output wire logic [EXP_W+FRAC_W-1:0] rounded,
	output wire logic                    inexact
);
	import fpres_pkg::*;

	// b is mag itself, c is mag plus one last place
	wire logic lsb    = mag[0];                    // parity of the lower candidate
	wire logic guard  = ext[EXT_W-1];              // half a last place
	wire logic sticky = |ext[EXT_W-2:0];           // anything below half
	wire logic frac_z = ~(guard | sticky);         // exact: no rounding at all

	// choose c over b per mode
	wire logic up_near  = guard & (sticky | lsb);  // ties go to the even candidate
	wire logic up_down  = sign & ~frac_z;          // toward minus: magnitude grows when negative
	wire logic up_up    = ~sign & ~frac_z;         // toward plus: magnitude grows when positive
	wire logic bump     = (rnd_mode == FPRES_RND_NEAR) ? up_near :   // RULE15
	                      (rnd_mode == FPRES_RND_DOWN) ? up_down :   // RULE16
	                      (rnd_mode == FPRES_RND_UP)   ? up_up   :   // RULE17
	                      1'h0;                                      // RULE18

	// carry out of the fraction walks into the exponent, which is the right next value
	assign rounded = mag + {{(EXP_W+FRAC_W-1){1'h0}}, bump};  // RULE14
	assign inexact = ~frac_z;                                  // RULE13

endmodule : fpres_round

/* File: rtl/fpres_top.sv */
`timescale 1ns/10ps
`include "fpres_defines.svh"

// Overview of operation
// [RULE1] unmasked signaling source: raise invalid, no write
// [RULE2] quieting sets top fraction bit only
// [RULE3] masked signaling source: sticky invalid, quiet result
// [RULE4] signaling plus quiet: stack quiet, packed first
// [RULE5] two signaling: stack larger, packed first, quieted
// [RULE6] two quiet: stack larger, packed first
// [RULE7] one NaN, one number: NaN, quieted
// [RULE8] single operand NaN returned, quieted
// [RULE9] masked invalid without NaN gives indefinite
// [RULE10] one indefinite encoding per format, both modes
// [RULE11] packed first operand is destination operand
// [RULE12] NaN payload passes unchanged except quiet bit
// [RULE13] exact when representable, else error below ulp
// [RULE14] round between two bracketing representable values
// [RULE15] code 00 nearest, ties to even
// [RULE16] code 01 toward minus infinity
// [RULE17] code 10 toward plus infinity
// [RULE18] code 11 truncate toward zero
// [RULE19] rounded result sets sticky inexact flag
// [RULE20] no rounding for compare, exact, NaN results
// [RULE21] NaN: exponent all ones, fraction nonzero
// [RULE22] top fraction bit set means quiet
// [RULE23] never deliver a signaling NaN
// [RULE24] pipeline gives two-bit rounding control per op
// [RULE25] pipeline gives unit mode per op
module fpres_top #(
	parameter int EXP_W  = `FPRES_EXP_W,
	parameter int FRAC_W = `FPRES_FRAC_W,
	parameter int EXT_W  = `FPRES_EXT_W
) (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic                       op_valid,
	input  wire logic                       op_single,
	input  wire logic                       op_cmp,
	input  wire fpres_pkg::fpres_mode_t     unit_mode,
	input  wire logic                       invalid_mask,
	input  wire logic                       invalid_other,
	input  wire logic [EXP_W+FRAC_W:0]      opnd_a,
	input  wire logic [EXP_W+FRAC_W:0]      opnd_b,
	input  wire logic                       exact_sign,
	input  wire logic [EXP_W+FRAC_W-1:0]    exact_mag,
	input  wire logic [EXT_W-1:0]           exact_ext,
	input  wire fpres_pkg::fpres_rnd_t      rounding_control_field,
	input  wire logic                       flag_clear,
	output wire logic                       res_valid,
	output wire logic                       res_write,
	output wire logic [EXP_W+FRAC_W:0]      res_data,
	output wire logic                       invalid_signal,
	output wire logic                       invalid_sticky_flag,
	output wire logic                       inexact_sticky_flag
);
	import fpres_pkg::*;

	// word layout
	localparam int W       = 1 + EXP_W + FRAC_W;     // whole value
	localparam int EXP_LSB = FRAC_W;                 // lowest exponent bit
	localparam int EXP_MSB = W - 2;                  // highest exponent bit
	localparam int Q_POS   = FRAC_W - 1;             // quiet bit position

	// quiet bit alone, as a mask over the whole word
	localparam logic [W-1:0] QUIET_MASK = {{(W-1){1'h0}}, 1'h1} << Q_POS;
	// indefinite follows the width parameters, so each format gets its own
	localparam logic [W-1:0] INDEF = {`FPRES_INDEF_SIGN, {EXP_W{1'h1}}, 1'h1, {(FRAC_W-1){1'h0}}}; // RULE10

	// operands side by side so classification is one loop
	wire logic [W-1:0] opnd [2];
	wire logic         is_nan [2];          // any NaN
	wire logic         is_sig [2];          // signaling NaN
	wire logic [W-1:0] quieted [2];         // operand with quiet bit forced

	assign opnd[0] = opnd_a;
	assign opnd[1] = opnd_b;

	// per operand classification and quieting
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cls
			// sign bit is not looked at
			wire logic exp_ones  = &opnd[gi][EXP_MSB:EXP_LSB];          // RULE21
			wire logic frac_nz   = |opnd[gi][FRAC_W-1:0];
			assign is_nan[gi]    = exp_ones & frac_nz;                  // RULE21
			assign is_sig[gi]    = is_nan[gi] & ~opnd[gi][Q_POS];       // RULE22
			// payload kept bit for bit; on a quiet NaN this is a no-op
			assign quieted[gi]   = opnd[gi] | QUIET_MASK;               // RULE2 RULE12
		end
	endgenerate

	// second operand counts only for two-operand instructions
	wire logic b_nan   = is_nan[1] & ~op_single;                      // RULE8
	wire logic b_sig   = is_sig[1] & ~op_single;
	wire logic both    = is_nan[0] & b_nan;
	wire logic any_nan = is_nan[0] | b_nan;
	wire logic any_sig = is_sig[0] | b_sig;

	// invalid condition: signaling source, or invalid raised on ordinary values
	wire logic invalid_cond = any_sig | (~any_nan & invalid_other);   // RULE9
	wire logic trap        = invalid_cond & ~invalid_mask;            // RULE1

	// larger significand; a tie keeps operand a
	wire logic b_larger = opnd_b[FRAC_W-1:0] > opnd_a[FRAC_W-1:0];    // RULE5 RULE6

	// legacy stack choice when both are NaNs
	wire logic stack_b = (is_sig[0] & ~is_sig[1]) ? 1'h1 :             // RULE4
	                     (~is_sig[0] & is_sig[1]) ? 1'h0 :             // RULE4
	                     b_larger;                                    // RULE5 RULE6

	// packed mode keys on order: operand a is the destination operand
	wire logic pick_b = both ? ((unit_mode == FPRES_MODE_STACK) ? stack_b : 1'h0) // RULE11 RULE25
	                         : b_nan;                                 // RULE7

	// every NaN result goes out quieted, so no signaling result can leave
	wire logic [W-1:0] nan_res = pick_b ? quieted[1] : quieted[0];    // RULE23

	// rounding of the exact result
	wire logic [W-2:0] rnd_mag;
	wire logic         rnd_inexact;

	fpres_round #(
		.EXP_W  (EXP_W),
		.FRAC_W (FRAC_W),
		.EXT_W  (EXT_W)
	) u_round (
		.sign     (exact_sign),
		.mag      (exact_mag),
		.ext      (exact_ext),
		.rnd_mode (rounding_control_field),                           // RULE24
		.rounded  (rnd_mag),
		.inexact  (rnd_inexact)
	);

	// ordinary result path; compares bypass the rounder
	wire logic [W-1:0] exact_word = {exact_sign, exact_mag};
	wire logic [W-1:0] num_res    = op_cmp ? exact_word : {exact_sign, rnd_mag}; // RULE20

	// result select: NaN before indefinite before number
	wire logic [W-1:0] sel_res = any_nan      ? nan_res :             // RULE3
	                             invalid_cond ? INDEF   :             // RULE9
	                             num_res;                             // RULE13

	// inexact only on a rounded ordinary result
	wire logic inexact_evt = op_valid & ~any_nan & ~invalid_cond & ~op_cmp & rnd_inexact; // RULE19 RULE20

	// state
	logic         res_valid_reg;            // one-cycle answer strobe
	logic         res_write_reg;            // destination written this answer
	logic [W-1:0] res_data_reg;             // last written result
	logic         invalid_signal_reg;       // unmasked invalid pulse
	logic         invalid_sticky_reg;       // sticky invalid flag
	logic         inexact_sticky_reg;       // sticky inexact flag

	// next values
	wire logic         res_write_next  = op_valid & ~trap;            // RULE1
	wire logic [W-1:0] res_data_next   = res_write_next ? sel_res : res_data_reg;
	wire logic         inv_sig_next    = op_valid & trap;             // RULE1
	// set beats clear so an event in the clearing cycle survives
	wire logic         inv_sticky_next = (op_valid & invalid_cond) |  // RULE3
	                                     (invalid_sticky_reg & ~flag_clear);
	wire logic         inx_sticky_next = inexact_evt |                // RULE19
	                                     (inexact_sticky_reg & ~flag_clear);

	// strobes and flags
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			res_valid_reg      <= 1'h0;
			res_write_reg      <= 1'h0;
			invalid_signal_reg <= 1'h0;
			invalid_sticky_reg <= 1'h0;
			inexact_sticky_reg <= 1'h0;
		end
		else
		begin
			res_valid_reg      <= op_valid;
			res_write_reg      <= res_write_next;
			invalid_signal_reg <= inv_sig_next;
			invalid_sticky_reg <= inv_sticky_next;
			inexact_sticky_reg <= inx_sticky_next;
		end
	end

	// result word; holds when the destination is left alone
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			res_data_reg <= {W{1'h0}};
		else
			res_data_reg <= res_data_next;                            // RULE1
	end

	assign res_valid           = res_valid_reg;
	assign res_write           = res_write_reg;
	assign res_data            = res_data_reg;
	assign invalid_signal      = invalid_signal_reg;
	assign invalid_sticky_flag = invalid_sticky_reg;
	assign inexact_sticky_flag = inexact_sticky_reg;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// output word classification
	wire logic out_nan = (&res_data_reg[EXP_MSB:EXP_LSB]) & (|res_data_reg[FRAC_W-1:0]);
	wire logic out_sig = out_nan & ~res_data_reg[Q_POS];
	wire logic nan_res_case = op_valid & any_nan & ~trap;

	property p_trap_no_write;
		op_valid & any_sig & ~invalid_mask
		|=> res_valid & ~res_write & invalid_signal & (res_data == $past(res_data));
	endproperty
	a_trap_no_write: assert property (p_trap_no_write) // RULE1
		else $error("unmasked signaling operand wrote the destination");

	property p_quiet_single;
		op_valid & op_single & is_sig[0] & invalid_mask
		|=> res_data == ($past(opnd_a) | QUIET_MASK);
	endproperty
	a_quiet_single: assert property (p_quiet_single) // RULE2 RULE8 RULE12
		else $error("single operand signaling NaN not quieted in place");

	property p_masked_sticky;
		op_valid & any_sig & invalid_mask
		|=> invalid_sticky_flag & res_write & ~invalid_signal & ~out_sig;
	endproperty
	a_masked_sticky: assert property (p_masked_sticky) // RULE3
		else $error("masked signaling operand lost flag or result");

	property p_packed_first;
		op_valid & both & (unit_mode == FPRES_MODE_PACKED) & ~trap
		|=> res_data == ($past(opnd_a) | QUIET_MASK);
	endproperty
	a_packed_first: assert property (p_packed_first) // RULE4 RULE5 RULE6 RULE11
		else $error("packed mode did not return first operand");

	property p_stack_quiet_wins;
		op_valid & both & (unit_mode == FPRES_MODE_STACK) & invalid_mask & is_sig[0] & ~is_sig[1]
		|=> res_data == $past(opnd_b);
	endproperty
	a_stack_quiet_wins: assert property (p_stack_quiet_wins) // RULE4
		else $error("stack mode did not return the quiet operand");

	property p_stack_larger;
		op_valid & both & (unit_mode == FPRES_MODE_STACK) & ~trap & (is_sig[0] == is_sig[1]) & b_larger
		|=> res_data == ($past(opnd_b) | QUIET_MASK);
	endproperty
	a_stack_larger: assert property (p_stack_larger) // RULE5 RULE6
		else $error("stack mode did not return the larger significand");

	property p_one_nan;
		op_valid & ~op_single & ~is_nan[0] & is_nan[1] & ~trap
		|=> res_data == ($past(opnd_b) | QUIET_MASK);
	endproperty
	a_one_nan: assert property (p_one_nan) // RULE7
		else $error("lone NaN operand not returned");

	property p_indef;
		op_valid & ~any_nan & invalid_other & invalid_mask
		|=> res_write & (res_data == INDEF) & invalid_sticky_flag;
	endproperty
	a_indef: assert property (p_indef) // RULE9 RULE10
		else $error("masked invalid did not give indefinite");

	property p_no_sig_out;
		res_valid & res_write |-> ~out_sig;
	endproperty
	a_no_sig_out: assert property (p_no_sig_out) // RULE23
		else $error("signaling NaN delivered");

	property p_exact_kept;
		op_valid & ~any_nan & ~invalid_cond & (exact_ext == {EXT_W{1'h0}})
		|=> (res_data == $past(exact_word)) & ($rose(inexact_sticky_flag) == 1'h0);
	endproperty
	a_exact_kept: assert property (p_exact_kept) // RULE13 RULE20
		else $error("exact result altered or flagged");

	property p_trunc;
		op_valid & ~any_nan & ~invalid_cond & (rounding_control_field == FPRES_RND_TRUNC)
		|=> res_data == $past(exact_word);
	endproperty
	a_trunc: assert property (p_trunc) // RULE18
		else $error("truncation changed the magnitude");

	property p_inexact;
		op_valid & ~any_nan & ~invalid_cond & ~op_cmp & (exact_ext != {EXT_W{1'h0}})
		|=> inexact_sticky_flag ##1 (inexact_sticky_flag | $past(flag_clear));
	endproperty
	a_inexact: assert property (p_inexact) // RULE19
		else $error("inexact flag not set or lost");

	property p_nan_no_inexact;
		nan_res_case & ~inexact_sticky_flag |=> ~inexact_sticky_flag;
	endproperty
	a_nan_no_inexact: assert property (p_nan_no_inexact) // RULE20
		else $error("NaN result raised inexact");

	// main scenarios
	c_trap:      cover property (op_valid & any_sig & ~invalid_mask ##1 invalid_signal);
	c_stack_two: cover property (op_valid & both & (unit_mode == FPRES_MODE_STACK) & invalid_mask);
	c_indef:     cover property (op_valid & ~any_nan & invalid_other & invalid_mask);
	c_tie_even:  cover property (inexact_evt & (rounding_control_field == FPRES_RND_NEAR)
	                             & (exact_ext == ({{(EXT_W-1){1'h0}}, 1'h1} << (EXT_W - 1))));

endmodule : fpres_top

/* File: tb/fpres_pipe_model.sv */
`timescale 1ns/10ps

package fpres_tbm_pkg;

	// one operation as the pipeline hands it over, all fields side by side
	typedef struct packed {
		logic                   valid;  // operation presented
		logic                   single; // one-operand instruction
		logic                   cmp;    // comparison, no rounding
		fpres_pkg::fpres_mode_t mode;   // issuing unit
		logic                   mask;   // invalid exception masked
		logic                   other;  // invalid found upstream
		logic [31:0]            a;      // first operand
		logic [31:0]            b;      // second operand
		logic                   es;     // exact sign
		logic [30:0]            em;     // exact magnitude, truncated
		logic [3:0]             ex;     // bits below the last place
		fpres_pkg::fpres_rnd_t  rnd;    // rounding_control_field
		logic                   clr;    // clear sticky flags
	} fpres_op_t;

endpackage : fpres_tbm_pkg

module fpres_pipe_model (
	input  wire logic                clk,
	output fpres_tbm_pkg::fpres_op_t op
);
	import fpres_tbm_pkg::*;

	// quiet lines at time zero; the caller fills idle slots with junk, not stale values
	initial op = '0;

	// one slot per rising edge; mode and rounding code travel with every op
	task automatic send(input fpres_op_t o);
		@(posedge clk);
		op <= o;
	endtask : send

endmodule : fpres_pipe_model

/* File: tb/fpres_top_test.sv */
`timescale 1ns/10ps

module fpres_top_test;
	import fpres_pkg::*;
	import fpres_tbm_pkg::*;

	// what the monitor expects for one accepted operation
	typedef struct packed {
		logic        wr;
		logic [31:0] data;
		logic        inv_sig;
		logic        inv_fl;
		logic        inx_fl;
	} fpres_note_t;

	logic        clk;                 // 20 MHz core clock
	logic        sys_rst;             // async reset, active high
	fpres_op_t   op;                  // pipeline lines
	logic        res_valid;
	logic        res_write;
	logic [31:0] res_data;
	logic        invalid_signal;
	logic        invalid_sticky_flag;
	logic        inexact_sticky_flag;
	fpres_note_t notes[$];            // expected results, oldest first
	fpres_note_t nt;                  // note under comparison
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	integer      seed = 32'h2985;
	logic        exp_inv = 1'h0;      // expected sticky flags
	logic        exp_inx = 1'h0;
	logic [31:0] last_data = 32'h0;   // destination word as last written

	fpres_pipe_model pipe (.clk(clk), .op(op));

	fpres_top #(.EXP_W(8), .FRAC_W(23), .EXT_W(4)) dut (
		.clk(clk), .sys_rst(sys_rst), .op_valid(op.valid), .op_single(op.single),
		.op_cmp(op.cmp), .unit_mode(op.mode), .invalid_mask(op.mask), .invalid_other(op.other),
		.opnd_a(op.a), .opnd_b(op.b), .exact_sign(op.es), .exact_mag(op.em), .exact_ext(op.ex),
		.rounding_control_field(op.rnd), .flag_clear(op.clr), .res_valid(res_valid),
		.res_write(res_write), .res_data(res_data), .invalid_signal(invalid_signal),
		.invalid_sticky_flag(invalid_sticky_flag), .inexact_sticky_flag(inexact_sticky_flag)
	);

	// free-running clock
	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	task automatic tally_and_finish();
		// a note still queued at the end means an operation got no answer
		chk(32'(notes.size()), 32'h0);
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
		begin
			$display("No errors found");
		end
		else
		begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// a hang is cut short well after the longest planned sequence
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	function automatic logic [31:0] quiet(input logic [31:0] x);
		return x | 32'h00400000;
	endfunction : quiet

	// operand of a chosen class: 0 signaling, 1 quiet, else ordinary number
	function automatic logic [31:0] mkval(input int k, input logic [31:0] r);
		case (k)
			0: return {r[31], 8'hFF, 1'h0, r[21:0] | 22'h1};
			1: return {r[31], 8'hFF, 1'h1, r[21:0]};
			default: return {r[31], ((r[30:23] == 8'hFF) ? 8'hFE : r[30:23]), r[22:0]};
		endcase
	endfunction : mkval

	// random lines; valid low so an idle slot never repeats the last op
	function automatic fpres_op_t junk();
		fpres_op_t o;
		o = $bits(fpres_op_t)'({$random(seed), $random(seed), $random(seed), $random(seed)});
		o.valid = 1'h0;
		o.em[30] = 1'h0; // keeps round-up away from magnitude wrap
		return o;
	endfunction : junk

	// reference result, worked out independently of the design
	task automatic predict(input fpres_op_t o);
		fpres_note_t n;
		logic        na;
		logic        nb;
		logic        sa;
		logic        sb;
		logic        inv;
		logic        inc;
		logic        inx;
		na = (&o.a[30:23]) && (|o.a[22:0]);
		nb = (&o.b[30:23]) && (|o.b[22:0]) && !o.single;
		sa = na && !o.a[22];
		sb = nb && !o.b[22];
		inv = sa || sb || (o.other && !na && !nb);
		n.wr = !(inv && !o.mask);
		n.inv_sig = inv && !o.mask;
		inx = 1'h0;
		inc = 1'h0;
		if (na && nb)
		begin
			if (o.mode == FPRES_MODE_PACKED)
				n.data = quiet(o.a);
			else if (sa != sb)
				n.data = sa ? o.b : o.a;
			else
				n.data = quiet((o.b[22:0] > o.a[22:0]) ? o.b : o.a);
		end
		else if (na)
			n.data = quiet(o.a);
		else if (nb)
			n.data = quiet(o.b);
		else if (o.other)
			n.data = 32'hFFC00000;
		else if (o.cmp)
			n.data = {o.es, o.em};
		else
		begin
			case (o.rnd)
				FPRES_RND_NEAR: inc = o.ex[3] && ((|o.ex[2:0]) || o.em[0]);
				FPRES_RND_DOWN: inc = o.es && (|o.ex);
				FPRES_RND_UP:   inc = !o.es && (|o.ex);
				default:        inc = 1'h0;
			endcase
			n.data = {o.es, o.em + 31'(inc)};
			inx = |o.ex;
		end
		if (!n.wr)
			n.data = last_data;
		last_data = n.data;
		exp_inv = (exp_inv && !o.clr) || inv;
		exp_inx = (exp_inx && !o.clr) || inx;
		n.inv_fl = exp_inv;
		n.inx_fl = exp_inx;
		notes.push_back(n);
	endtask : predict

	// hand one slot to the pipeline and note what must come back
	task automatic issue(input fpres_op_t o);
		pipe.send(o);
		if (o.valid)
			predict(o);
		else
		begin
			exp_inv = exp_inv && !o.clr;
			exp_inx = exp_inx && !o.clr;
		end
	endtask : issue

	task automatic rand_op(input int ka, input int kb);
		fpres_op_t   o;
		logic [31:0] r;
		o = junk();
		r = $random(seed);
		o.valid = 1'h1;
		o.a = mkval(ka, o.a);
		o.b = mkval(kb, o.b);
		o.other = (ka == 2) && (kb == 2) && r[0] && r[1]; // only without NaN operands
		o.cmp = o.cmp && (ka == 2) && (kb == 2) && r[2];
		o.clr = o.clr && r[3];
		issue(o);
	endtask : rand_op

	// results are settled by the falling edge
	always @(negedge clk)
	begin
		if (!sys_rst && res_valid !== 1'h0)
		begin
			if (notes.size() == 0)
				chk(32'(res_valid), 32'h0);
			else
			begin
				nt = notes.pop_front();
				chk(32'(res_write), 32'(nt.wr));
				chk(res_data, nt.data);
				chk(32'(invalid_signal), 32'(nt.inv_sig));
				chk(32'(invalid_sticky_flag), 32'(nt.inv_fl));
				chk(32'(inexact_sticky_flag), 32'(nt.inx_fl));
			end
		end
	end

	initial
	begin
		fpres_op_t o;
		logic [3:0] tails[6];
		tails = '{4'h0, 4'h8, 4'h8, 4'hC, 4'h7, 4'h1};
		sys_rst = 1'h1;
		repeat (10) @(posedge clk);
		sys_rst <= 1'h0;
		// every rounding code against exact, tie-odd, tie-even, above and below half
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 2; s++)
				for (int i = 0; i < 6; i++)
				begin
					o = junk();
					o.valid = 1'h1;
					o.cmp = 1'h0;
					o.other = 1'h0;
					o.a = mkval(2, o.a);
					o.b = mkval(2, o.b);
					o.rnd = fpres_rnd_t'(m);
					o.es = s[0];
					o.ex = tails[i];
					o.em = 31'h3F800000 | 31'(i % 2);
					issue(o);
				end
		// every class pairing, random modes, masks, flag clears and idle gaps
		for (int k = 0; k < 360; k++)
		begin
			if ($random(seed) % 4 == 0)
				issue(junk());
			rand_op(k % 3, (k / 3) % 3);
		end
		// two signaling NaNs with equal payload in stack mode: first one wins
		o = junk();
		o.valid = 1'h1;
		o.single = 1'h0;
		o.mask = 1'h1;
		o.mode = FPRES_MODE_STACK;
		o.a = 32'h7FA00001;
		o.b = 32'hFFA00001;
		issue(o);
		issue(junk());
		repeat (4) @(posedge clk);
		tally_and_finish();
	end

endmodule : fpres_top_test
